// ==== rtl/smf_pkg.sv ====
/*
 * smf_pkg: shared constants and carrier types for the two-wire management
 * bus slave framing block.
 * Assumes a single system clock domain; bus pins are sampled, never used as clocks.
 */
package smf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // address map of the bus
    localparam logic [6:0] SMF_ADDR_HOST = 7'h08;
    localparam logic [6:0] SMF_ADDR_ALERT = 7'h0c;
    localparam logic [6:0] SMF_ADDR_DEFAULT = 7'h61;
    localparam logic [6:0] SMF_ADDR_AB_HOST = 7'h28;
    localparam logic [6:0] SMF_ADDR_AB_DEFAULT = 7'h37;
    // 0000xxx and 1111xxx groups, compared on the upper four bits
    localparam logic [3:0] SMF_RSV_LOW_HI = 4'h0;
    localparam logic [3:0] SMF_RSV_HIGH_HI = 4'hf;
    // 10010xx prototype group, compared on the upper five bits
    localparam logic [4:0] SMF_PROTO_HI = 5'h12;

    ////////////////////////////////////////////////////////////////////////////
    // framing
    localparam logic [2:0] SMF_BIT_LAST = 3'h7;
    localparam logic SMF_DIR_WRITE = 1'b0;
    localparam logic SMF_DIR_READ = 1'b1;
    localparam int SMF_STRAP_W = 9;
    localparam int SMF_SYNC_W = SMF_STRAP_W + 2;
    localparam logic [1:0] SMF_STRAP_WAIT = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0] data;
        logic is_cmd;
    } smf_rx_type;

    typedef struct packed {
        logic selected;
        logic read;
        logic addr_ok;
    } smf_status_type;

endpackage

// ==== rtl/smf_sync.sv ====
/*
 * smf_sync: two flip-flop synchroniser, one stage pair per bit.
 * Assumes inputs are asynchronous to clk_sys; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module smf_sync #(
    parameter int WIDTH = smf_pkg::SMF_SYNC_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // asynchronous in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import smf_pkg::*;

    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    meta[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

// ==== rtl/smf_addr_check.sv ====
/*
 * smf_addr_check: picks the own slave address and vets it against the
 * reserved and special groups of the bus.
 * Assumes captured straps that stay stable between resets.
 */
`timescale 1ns/1ps
module smf_addr_check (
    // captured straps
    input wire logic [6:0] strap_addr,
    input wire logic host_mode,
    input wire logic proto_mode,
    // result
    output logic [6:0] own_addr,
    output logic own_ok
);
    import smf_pkg::*;

    logic reserved;
    logic special;
    logic proto;

    always_comb begin
        // a host always answers at the lowest assigned address
        own_addr = host_mode ? SMF_ADDR_HOST : strap_addr;
        // general call, start byte, 0000001..0000111 and 1111xxx
        reserved = (own_addr[6:3] == SMF_RSV_LOW_HI) || (own_addr[6:3] == SMF_RSV_HIGH_HI);
        special = (own_addr == SMF_ADDR_ALERT)
            || (own_addr == SMF_ADDR_DEFAULT)
            || (own_addr == SMF_ADDR_AB_HOST) || (own_addr == SMF_ADDR_AB_DEFAULT)
            || (!host_mode && own_addr == SMF_ADDR_HOST);
        // prototype range only accepted when the part is strapped experimental
        proto = (own_addr[6:2] == SMF_PROTO_HI) && !proto_mode;
        own_ok = !reserved && !special && !proto;
    end

endmodule

// ==== rtl/smf_slave.sv ====
/*
 * smf_slave: slave side framing of the two-wire management bus: address
 * phase, direction, acknowledge, byte streams in both directions.
 * Assumes a master that generates the clock on scl and ends with STOP;
 * user logic on clk_sys judges received bytes and supplies read data.
 */
`timescale 1ns/1ps
module smf_slave (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bus pins, sda open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic [6:0] strap_addr,
    input wire logic strap_host,
    input wire logic strap_proto,
    // received stream
    output smf_pkg::smf_rx_type rx,
    output logic rx_valid,
    input wire logic byte_ok,
    output logic cmd_error,
    // transmit stream
    input wire logic [7:0] tx_data,
    output logic tx_take,
    // status
    output smf_pkg::smf_status_type status
);
    import smf_pkg::*;

    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_ack_set,
        st_ack_hold,
        st_rx,
        st_tx,
        st_tx_ack,
        st_tx_next,
        st_ignore
    } smf_state_type;

    ////////////////////////////////////////////////////////////////////////////
    // pin and strap synchronisation
    logic [SMF_SYNC_W-1:0] sync_q;
    logic scl_s, sda_s, scl_d, sda_d;

    smf_sync #(.WIDTH(SMF_SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in({strap_proto, strap_host, strap_addr, sda_in, scl_in}),
        .sync_out(sync_q)
    );

    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev;

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    // sda moving while scl stays high frames a transfer
    assign start_ev = scl_s && scl_d && sda_d && !sda_s;
    assign stop_ev = scl_s && scl_d && !sda_d && sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    logic [1:0] cap_cnt, next_cap_cnt;
    logic [SMF_STRAP_W-1:0] strap, next_strap;

    always_comb begin
        next_cap_cnt = cap_cnt;
        next_strap = strap;
        // wait out the synchroniser latency, then freeze the straps
        if (cap_cnt != SMF_STRAP_WAIT) begin
            next_cap_cnt = 2'(cap_cnt + 2'h1);
            next_strap = sync_q[SMF_SYNC_W-1:2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cap_cnt <= 2'h0;
            strap <= '0;
        end else begin
            cap_cnt <= next_cap_cnt;
            strap <= next_strap;
        end
    end

    logic [6:0] own_addr;
    logic own_ok, straps_ready;

    assign straps_ready = (cap_cnt == SMF_STRAP_WAIT);

    smf_addr_check u_addr (
        .strap_addr(strap[6:0]),
        .host_mode(strap[7]),
        .proto_mode(strap[8]),
        .own_addr(own_addr),
        .own_ok(own_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // framing state machine
    smf_state_type state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [7:0] shift, next_shift, full;
    logic drive, next_drive;
    logic ack_bit, next_ack_bit;
    logic judge, next_judge;
    logic first, next_first;
    logic read, next_read;
    logic selected, next_selected;
    smf_rx_type next_rx;
    logic next_rx_valid, next_tx_take, next_cmd_error;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_drive = drive;
        next_ack_bit = ack_bit;
        next_judge = judge;
        next_first = first;
        next_read = read;
        next_selected = selected;
        next_rx = rx;
        next_rx_valid = 1'b0;
        next_tx_take = 1'b0;
        next_cmd_error = 1'b0;
        full = {shift[6:0], sda_s};
        if (stop_ev) begin
            // only the master ends a transfer
            next_state = st_idle;
            next_drive = 1'b0;
            next_selected = 1'b0;
        end else if (start_ev) begin
            // a repeated start drops the old frame and reopens addressing
            next_state = st_addr;
            next_cnt = 3'h0;
            next_drive = 1'b0;
            next_selected = 1'b0;
        end else begin
            unique case (state)
                st_idle, st_ignore: begin
                    next_drive = 1'b0;
                end
                st_addr: begin
                    if (scl_rise) begin
                        next_shift = full;
                        next_cnt = 3'(cnt + 3'h1);
                        if (cnt == SMF_BIT_LAST) begin
                            // seven address bits then the direction bit
                            if (straps_ready && own_ok && full[7:1] == own_addr) begin
                                next_state = st_ack_set;
                                next_ack_bit = 1'b1;
                                next_judge = 1'b0;
                                next_read = (full[0] == SMF_DIR_READ);
                                next_first = (full[0] == SMF_DIR_WRITE);
                                next_selected = 1'b1;
                            end else begin
                                // general call and foreign addresses are not ours
                                next_state = st_ignore;
                            end
                        end
                    end
                end
                st_rx: begin
                    if (scl_rise) begin
                        next_shift = full;
                        next_cnt = 3'(cnt + 3'h1);
                        if (cnt == SMF_BIT_LAST) begin
                            // whole byte: command first, then arguments
                            next_rx.data = full;
                            next_rx.is_cmd = first;
                            next_rx_valid = 1'b1;
                            next_first = 1'b0;
                            next_judge = 1'b1;
                            next_state = st_ack_set;
                        end
                    end
                end
                st_ack_set: begin
                    if (scl_fall) begin
                        if (judge) begin
                            // user logic has had the byte since the last rise
                            next_ack_bit = byte_ok;
                            next_drive = byte_ok;
                            next_cmd_error = !byte_ok && rx.is_cmd;
                        end else begin
                            next_drive = ack_bit;
                        end
                        next_state = st_ack_hold;
                    end
                end
                st_ack_hold: begin
                    if (scl_fall) begin
                        next_cnt = 3'h0;
                        if (!ack_bit) begin
                            // master must stop and retry after our nack
                            next_drive = 1'b0;
                            next_state = st_ignore;
                        end else if (read) begin
                            next_shift = tx_data;
                            next_tx_take = 1'b1;
                            next_drive = !tx_data[7];
                            next_state = st_tx;
                        end else begin
                            next_drive = 1'b0;
                            next_state = st_rx;
                        end
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        if (cnt == SMF_BIT_LAST) begin
                            // free the line for the master's acknowledge
                            next_drive = 1'b0;
                            next_state = st_tx_ack;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_cnt = 3'(cnt + 3'h1);
                            next_drive = !shift[6];
                        end
                    end
                end
                st_tx_ack: begin
                    if (scl_rise) begin
                        // a nack marks the last byte the master wants
                        next_state = sda_s ? st_ignore : st_tx_next;
                    end
                end
                st_tx_next: begin
                    if (scl_fall) begin
                        next_shift = tx_data;
                        next_tx_take = 1'b1;
                        next_cnt = 3'h0;
                        next_drive = !tx_data[7];
                        next_state = st_tx;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= st_idle;
            cnt <= 3'h0;
            shift <= 8'h00;
            drive <= 1'b0;
            ack_bit <= 1'b0;
            judge <= 1'b0;
            first <= 1'b0;
            read <= 1'b0;
            selected <= 1'b0;
            rx <= '0;
            rx_valid <= 1'b0;
            tx_take <= 1'b0;
            cmd_error <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            drive <= next_drive;
            ack_bit <= next_ack_bit;
            judge <= next_judge;
            first <= next_first;
            read <= next_read;
            selected <= next_selected;
            rx <= next_rx;
            rx_valid <= next_rx_valid;
            tx_take <= next_tx_take;
            cmd_error <= next_cmd_error;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = drive;
    // one driver for the whole status word: selected, read, addr_ok
    assign status = {selected, read, own_ok && straps_ready};

endmodule

// ==== bench/smf_slave_asserts.sv ====
/*
 * smf_slave_asserts: port level properties of the slave framing block.
 * Assumes it is bound onto smf_slave and sees one clk_sys domain.
 */
`timescale 1ns/1ps
module smf_slave_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // straps
    input wire logic [6:0] strap_addr,
    input wire logic strap_host,
    input wire logic strap_proto,
    // streams and status
    input wire smf_pkg::smf_rx_type rx,
    input wire logic rx_valid,
    input wire logic byte_ok,
    input wire logic cmd_error,
    input wire logic [7:0] tx_data,
    input wire logic tx_take,
    input wire smf_pkg::smf_status_type status
);
    import smf_pkg::*;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    reset_clear_a: assert property ($fell(reset) |-> !sda_oe && !rx_valid && !tx_take && status == '0)
        else $error("outputs not cleared by reset");
    sda_low_a: assert property (sda_out == 1'b0)
        else $error("open drain value not low");
    // edges only while scl is low, never a false start or stop
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda driver changed while scl high");
    oe_owner_a: assert property (sda_oe |-> status.selected && status.addr_ok)
        else $error("sda driven without legal own address match");
    rx_write_a: assert property (rx_valid |-> status.selected && status.read == SMF_DIR_WRITE)
        else $error("byte received outside write direction");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid [*8])
        else $error("received byte pulse too long");
    take_read_a: assert property (tx_take |-> status.selected && status.read == SMF_DIR_READ)
        else $error("transmit load outside read direction");
    take_pulse_a: assert property (tx_take |=> !tx_take [*8])
        else $error("transmit load pulse too long");
    cmd_err_a: assert property (cmd_error |-> rx.is_cmd)
        else $error("error flag on a non command byte");
    nack_err_a: assert property (cmd_error |-> !sda_oe)
        else $error("refused command acknowledged");
    stop_release_a: assert property (scl_in && $rose(sda_in) |-> ##[1:8] !status.selected)
        else $error("selection survives stop");

    cover property (rx_valid && rx.is_cmd);
    cover property (tx_take);
    cover property (cmd_error);
    cover property (status.selected && status.read);
endmodule

bind smf_slave smf_slave_asserts i_smf_slave_asserts (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_addr(strap_addr), .strap_host(strap_host), .strap_proto(strap_proto),
    .rx(rx), .rx_valid(rx_valid), .byte_ok(byte_ok), .cmd_error(cmd_error), .tx_data(tx_data),
    .tx_take(tx_take), .status(status)
);

// ==== bench/smf_master_model.sv ====
/*
 * smf_master_model: behavioural bus master, 160 ns bit time.
 * Assumes a pull-up on sda resolved by the bench; scl stands high between frames.
 */
`timescale 1ns/1ps
module smf_master_model (
    // bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // also serves as repeated start, no stop first
    task automatic m_start();
        #40 sda_pull = 1'b0;
        #40 scl = 1'b1;
        #80 sda_pull = 1'b1;
        #80 scl = 1'b0;
    endtask

    task automatic m_stop();
        #40 sda_pull = 1'b1;
        #40 scl = 1'b1;
        #80 sda_pull = 1'b0;
        #80;
    endtask

    task automatic m_bit(input logic b, output logic r);
        #40 sda_pull = !b;
        #40 scl = 1'b1;
        r = sda_line;
        #80 scl = 1'b0;
    endtask

    // d all ones to read; mack is the level sent in the acknowledge slot
    task automatic m_byte(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            m_bit(d[i], q[i]);
        end
        m_bit(mack, ak);
    endtask
endmodule

// ==== bench/smf_slave_tb_top.sv ====
/*
 * smf_slave_tb_top: self-checking bench of the slave framing block.
 * Assumes smf_master_model on the bus and the checker bound to the design.
 */
`timescale 1ns/1ps
module smf_slave_tb_top;
    import smf_pkg::*;

    typedef struct packed {
        logic [6:0] strap;
        logic host;
        logic proto;
        logic [6:0] addr;
        logic ack;
        logic ok;
    } smf_row_type;

    // strap, host, proto, bus address, acknowledge, address legal
    localparam smf_row_type rows [16] = '{
        {7'h50, 2'h0, 7'h50, 2'h3}, {7'h50, 2'h0, 7'h51, 2'h1}, {7'h50, 2'h0, 7'h00, 2'h1},
        {7'h00, 2'h0, 7'h00, 2'h0}, {7'h02, 2'h0, 7'h02, 2'h0}, {7'h05, 2'h0, 7'h05, 2'h0},
        {7'h7b, 2'h0, 7'h7b, 2'h0}, {7'h7d, 2'h0, 7'h7d, 2'h0}, {7'h0c, 2'h0, 7'h0c, 2'h0},
        {7'h61, 2'h0, 7'h61, 2'h0}, {7'h28, 2'h0, 7'h28, 2'h0}, {7'h37, 2'h0, 7'h37, 2'h0},
        {7'h49, 2'h0, 7'h49, 2'h0}, {7'h49, 2'h1, 7'h49, 2'h3}, {7'h50, 2'h2, 7'h08, 2'h3},
        {7'h08, 2'h0, 7'h08, 2'h0}
    };

    logic clk_sys, reset, scl, sda_pull, sda_line, sda_out, sda_oe;
    logic strap_host, strap_proto, rx_valid, byte_ok, cmd_error, tx_take, ak;
    logic [6:0] strap_addr;
    logic [7:0] tx_data, q;
    smf_rx_type rx, last_rx;
    smf_status_type status;
    int n_errors, compares, n_rx, n_take, n_err, cyc;

    // wired and with a pull-up
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    smf_master_model i_smf_master_model (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

    smf_slave i_smf_slave (
        .clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap_addr(strap_addr), .strap_host(strap_host), .strap_proto(strap_proto),
        .rx(rx), .rx_valid(rx_valid), .byte_ok(byte_ok), .cmd_error(cmd_error), .tx_data(tx_data),
        .tx_take(tx_take), .status(status)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse watchers; next read byte offered right after each load
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rx_valid) begin
            last_rx <= rx;
            n_rx <= n_rx + 1;
        end
        if (cmd_error) n_err <= n_err + 1;
        if (tx_take) begin
            n_take <= n_take + 1;
            tx_data <= #1 tx_data ^ 8'h55;
        end
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // straps are caught only after a reset, so every address case resets
    task automatic rst(input logic [6:0] a, input logic h, input logic p);
        @(posedge clk_sys) #1 reset = 1'b1;
        strap_addr = a;
        strap_host = h;
        strap_proto = p;
        repeat (6) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (6) @(posedge clk_sys);
        // keep every bus event off the sampling edge
        #1;
        n_rx = 0;
        n_take = 0;
        n_err = 0;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        strap_addr = 7'h50;
        strap_host = 1'b0;
        strap_proto = 1'b0;
        byte_ok = 1'b1;
        tx_data = 8'hc3;
        foreach (rows[i]) begin
            rst(rows[i].strap, rows[i].host, rows[i].proto);
            check(status.addr_ok, rows[i].ok);
            i_smf_master_model.m_start();
            i_smf_master_model.m_byte({rows[i].addr, SMF_DIR_WRITE}, 1'b1, q, ak);
            check(!ak, rows[i].ack);
            check(status.selected, rows[i].ack);
            i_smf_master_model.m_stop();
        end
        // write: command then data, device stays receiver
        rst(7'h50, 1'b0, 1'b0);
        i_smf_master_model.m_start();
        i_smf_master_model.m_byte({7'h50, SMF_DIR_WRITE}, 1'b1, q, ak);
        i_smf_master_model.m_byte(8'ha5, 1'b1, q, ak);
        check(ak, 1'b0);
        check(last_rx, {8'ha5, 1'b1});
        i_smf_master_model.m_byte(8'h3c, 1'b1, q, ak);
        check({ak, status.read}, 2'h0);
        check(last_rx, {8'h3c, 1'b0});
        i_smf_master_model.m_stop();
        repeat (8) @(posedge clk_sys);
        #1;
        check({status.selected, 8'(n_rx)}, {1'b0, 8'h2});
        // refused command, rest of frame ignored
        i_smf_master_model.m_start();
        i_smf_master_model.m_byte({7'h50, SMF_DIR_WRITE}, 1'b1, q, ak);
        @(posedge clk_sys) #1 byte_ok = 1'b0;
        i_smf_master_model.m_byte(8'hee, 1'b1, q, ak);
        check({ak, 8'(n_err)}, {1'b1, 8'h1});
        @(posedge clk_sys) #1 byte_ok = 1'b1;
        i_smf_master_model.m_byte(8'h11, 1'b1, q, ak);
        check(ak, 1'b1);
        i_smf_master_model.m_stop();
        // combined: command, repeated start, two bytes read
        i_smf_master_model.m_start();
        i_smf_master_model.m_byte({7'h50, SMF_DIR_WRITE}, 1'b1, q, ak);
        i_smf_master_model.m_byte(8'h10, 1'b1, q, ak);
        i_smf_master_model.m_start();
        i_smf_master_model.m_byte({7'h50, SMF_DIR_READ}, 1'b1, q, ak);
        check({ak, status.read}, 2'h1);
        i_smf_master_model.m_byte(8'hff, 1'b0, q, ak);
        check(q, 8'hc3);
        i_smf_master_model.m_byte(8'hff, 1'b1, q, ak);
        check(q, 8'h96);
        i_smf_master_model.m_stop();
        repeat (8) @(posedge clk_sys);
        #1;
        check({status.selected, 8'(n_take)}, {1'b0, 8'h2});
        wrap_up();
    end
endmodule
